// ---- test/chf_channel_monitor.sv ----
`timescale 1ns/1ps
module chf_channel_monitor (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // command port
  input wire logic               cmd_valid,
  input wire logic [7:0]         cmd_data,
  input wire logic               cmd_ready,
  input wire logic               rsp_valid,
  input wire logic [7:0]         rsp_data,
  input wire logic               rsp_ready,
  // test states and sample path
  input wire chf_pkg::chf_test_t test,
  input wire logic [4:0]         analog_impedance_scaling,
  input wire logic               sample_tick,
  input wire logic               analog_out_en,
  input wire logic               transmit_irq,
  // transmit slot
  input wire logic               slot_tick,
  input wire logic               pcm_transmit_out_oe,
  input wire logic               transmit_slot_strobe,
  input wire logic               transmit_slot_strobe_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  // reset, slot, loopback, interrupt and answer checks
  reset_clear_a: assert property (disable iff (1'h0)
    rst |=> !rsp_valid && !transmit_irq && analog_out_en)
    else $error("outputs not cleared by reset");
  cutoff_float_a: assert property (
    slot_tick && test.transmit_cutoff
    |=> !pcm_transmit_out_oe && !transmit_slot_strobe_oe)
    else $error("slot driven during transmit cutoff");
  slot_drive_a: assert property (
    slot_tick && !test.transmit_cutoff
    |=> pcm_transmit_out_oe && transmit_slot_strobe && transmit_slot_strobe_oe)
    else $error("slot not driven");
  oe_cause_a: assert property (
    pcm_transmit_out_oe
    |-> $past(slot_tick) && !$past(test.transmit_cutoff))
    else $error("slot output without a slot");
  loop_analog_off_a: assert property (
    (test.full_digital_loopback
     || analog_impedance_scaling == chf_pkg::AIS_LOOPBACK_CODE)
    && !test.receive_cutoff && !test.transmit_cutoff |=> !analog_out_en)
    else $error("analog output on in full loopback");
  irq_set_a: assert property (
    sample_tick && test.transmit_data_irq_arm |=> transmit_irq)
    else $error("armed interrupt not raised");
  irq_cause_a: assert property (
    $rose(transmit_irq)
    |-> $past(sample_tick) && $past(test.transmit_data_irq_arm))
    else $error("interrupt without armed sample");
  read_answer_a: assert property (
    cmd_valid && cmd_ready && !rsp_valid
    && cmd_data == chf_pkg::CMD_CONTACT_RD
    |=> !cmd_ready ##1 rsp_valid) else $error("read answer late");
  answer_hold_a: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("answer byte lost while stalled");
endmodule

// ---- test/chf_host_model.sv ----
`timescale 1ns/1ps
module chf_host_model (
  // clock
  input  wire logic       clk,
  // command bytes out
  output logic            cmd_valid,
  output logic [7:0]      cmd_data,
  input  wire logic       cmd_ready,
  // answer bytes in
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  output logic            rsp_ready
);
  int n;
  // idle port at time zero
  initial begin
    cmd_valid = 1'h0;
    cmd_data  = 8'h00;
    rsp_ready = 1'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // offer a byte, held until an edge takes it
  task automatic put(input logic [7:0] b);
    cmd_valid = 1'h1;
    cmd_data  = b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!cmd_ready && n < 100);
    #2;
  endtask
  // release everything; a released data line shows no stale byte
  task automatic rel();
    cmd_valid = 1'h0;
    cmd_data  = ~cmd_data;
    rsp_ready = 1'h0;
    @(posedge clk);
    #2;
  endtask
  // take one answer byte, after stalling some cycles
  task automatic get(input int stall, output logic [7:0] b);
    cmd_valid = 1'h0;
    rsp_ready = (stall == 0);
    repeat (stall) @(posedge clk);
    if (stall > 0) #2 rsp_ready = 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!rsp_valid && n < 100);
    b = rsp_data;
    #2;
  endtask
  // contact filter period write and read, reserved bits sent as zero
  task automatic wr_period(input logic [3:0] p);
    put(chf_pkg::CMD_CONTACT_WR);
    put({4'h0, p});
    rel();
  endtask
  task automatic rd_period(output logic [7:0] b);
    put(chf_pkg::CMD_CONTACT_RD);
    get(0, b);
    rel();
  endtask
  // transmit sample read: upper byte, then reserved byte after a stall
  task automatic rd_tx(output logic [7:0] b1, output logic [7:0] b2);
    put(chf_pkg::CMD_TX_READ);
    get(0, b1);
    get(3, b2);
    rel();
  endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
bind chf_channel chf_channel_monitor chf_channel_monitor_inst (
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_ready(rsp_ready), .test(test), .sample_tick(sample_tick),
  .analog_impedance_scaling(analog_impedance_scaling),
  .analog_out_en(analog_out_en), .transmit_irq(transmit_irq),
  .slot_tick(slot_tick), .pcm_transmit_out_oe(pcm_transmit_out_oe),
  .transmit_slot_strobe(transmit_slot_strobe),
  .transmit_slot_strobe_oe(transmit_slot_strobe_oe));
module tb;
  localparam int MSC   = 4;
  localparam int LIMIT = 5000;
  // one table row: period written, period read back
  typedef struct packed {
    logic [3:0] wr;
    logic [3:0] rd;
  } chf_row_t;
  logic               clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic               sample_tick, slot_tick, analog_out_en, transmit_irq;
  logic               pcm_transmit_out_oe, transmit_slot_strobe;
  logic               transmit_slot_strobe_oe, contact_state, nz;
  logic               line_detect_second_input;
  logic [7:0]         cmd_data, rsp_data, pcm_transmit_out, b1, b2;
  logic [4:0]         analog_impedance_scaling;
  logic signed [15:0] rx_slot_sample, analog_in, analog_out;
  logic [3:0][15:0]   rx_fir_coef;
  chf_pkg::chf_test_t test;
  chf_pkg::chf_coef_t coef;
  int                 n_errors = 0, checks = 0, cyc = 0;
  chf_row_t           rows [5] = '{'{4'h5, 4'h5}, '{4'hF, 4'hF},
                                   '{4'h1, 4'h1}, '{4'hA, 4'hA},
                                   '{4'h0, 4'h0}};
  //////////////////////////////////////////////////////////////////////////
  // design and host
  chf_channel #(.MS_CYCLES(MSC)) chf_channel_inst (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ready(rsp_ready), .test(test), .coef(coef),
    .analog_impedance_scaling(analog_impedance_scaling),
    .rx_fir_coef(rx_fir_coef), .sample_tick(sample_tick),
    .rx_slot_sample(rx_slot_sample), .analog_in(analog_in),
    .analog_out(analog_out), .analog_out_en(analog_out_en),
    .slot_tick(slot_tick), .pcm_transmit_out(pcm_transmit_out),
    .pcm_transmit_out_oe(pcm_transmit_out_oe),
    .transmit_slot_strobe(transmit_slot_strobe),
    .transmit_slot_strobe_oe(transmit_slot_strobe_oe),
    .transmit_irq(transmit_irq), .contact_state(contact_state),
    .line_detect_second_input(line_detect_second_input));
  chf_host_model host_inst (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ready(rsp_ready));
  // 40 MHz clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // counts, verdict and end of run
  task automatic test_done();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one sample tick or slot tick pulse
  task automatic tick();
    sample_tick = 1'h1;
    @(posedge clk);
    #2 sample_tick = 1'h0;
    repeat (3) @(posedge clk);
    #2;
  endtask
  task automatic slot();
    slot_tick = 1'h1;
    @(posedge clk);
    #2 slot_tick = 1'h0;
  endtask
  // cycle ceiling against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'h1;
    test = '0;
    analog_impedance_scaling = 5'h00;
    coef = '{tx_gain: 16'h7770, rx_gain: 16'h7770, eq_pole: 16'h7777,
             z_pole: 16'h7777, z_post: 8'h77, b_fir: 12'h777,
             b_pole: 16'h7777};
    rx_fir_coef = '{16'h7777, 16'h7777, 16'h7777, 16'h7770};
    sample_tick = 1'h0;
    slot_tick = 1'h0;
    rx_slot_sample = 16'hA55A;
    analog_in = 16'h1234;
    line_detect_second_input = 1'h0;
    repeat (16) @(posedge clk);
    #2 rst = 1'h0;
    @(posedge clk);
    #2 chk(analog_out_en, 1'h1);
    host_inst.rd_period(b1);
    chk(b1[3:0], 4'h0);
    foreach (rows[i]) begin
      host_inst.wr_period(rows[i].wr);
      host_inst.rd_period(b1);
      chk(b1[3:0], rows[i].rd);
    end
    // bypassed filter follows the pin; period 15 holds it for 15 ms
    line_detect_second_input = 1'h1;
    repeat (4) @(posedge clk);
    #2 chk(contact_state, 1'h1);
    host_inst.wr_period(4'hF);
    line_detect_second_input = 1'h0;
    repeat (20) @(posedge clk);
    #2 chk(contact_state, 1'h1);
    repeat (15 * MSC + 5) @(posedge clk);
    #2 chk(contact_state, 1'h0);
    // slot loopback, then cutoff wins over it
    test.slot_loopback = 1'h1;
    tick();
    slot();
    chk(pcm_transmit_out, 8'hA5);
    @(posedge clk);
    #2 test.transmit_cutoff = 1'h1;
    slot();
    chk(pcm_transmit_out_oe, 1'h0);
    // armed interrupt raised by a sample, cleared by reading it
    test = '{transmit_data_irq_arm: 1'h1, default: 1'h0};
    tick();
    chk(transmit_irq, 1'h1);
    host_inst.rd_tx(b1, b2);
    chk(b2, chf_pkg::TX_BYTE2_VALUE);
    chk(transmit_irq, 1'h0);
    // slot sends the byte just read
    slot();
    chk(pcm_transmit_out, b1);
    test = '0;
    tick();
    chk(transmit_irq, 1'h0);
    // full loopback by test bit and by scaling code
    for (int i = 0; i < 2; i++) begin
      test.full_digital_loopback = (i == 1);
      analog_impedance_scaling = (i == 0) ? 5'h10 : 5'h00;
      repeat (2) @(posedge clk);
      #2 chk(analog_out_en, 1'h0);
    end
    test = '{receive_cutoff: 1'h1, receive_tone_inject: 1'h1,
             transmit_highpass_disable: 1'h1, default: 1'h0};
    // second reset mid-run, then cutoff blocks the tone
    rst = 1'h1;
    rx_slot_sample = 16'h0000;
    repeat (2) @(posedge clk);
    #2 rst = 1'h0;
    chk(analog_out_en, 1'h1);
    host_inst.rd_period(b1);
    chk(b1[3:0], 4'h0);
    for (int i = 0; i < 12; i++) begin
      tick();
      chk(analog_out, 16'h0000);
    end
    // 0x1234 with no highpass, times 1 + 1.0077
    slot();
    chk(pcm_transmit_out, 8'h24);
    test.receive_cutoff = 1'h0;
    nz = 1'h0;
    for (int i = 0; i < 12; i++) begin
      tick();
      nz = nz | (analog_out != 16'h0000);
    end
    chk(nz, 1'h1);
    test_done();
  end
endmodule

// ---- verilog/chf_buf2.sv ----
`timescale 1ns/1ps
module chf_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  typedef struct packed {
    logic [W-1:0] d0;
    logic [W-1:0] d1;
    logic [1:0]   cnt;
    logic         vld;
    logic         rdy;
  } chf_buf_state_t;

  chf_buf_state_t s_reg;
  chf_buf_state_t s_next;
  logic           push;
  logic           pop;
  logic [1:0]     pos;

  ////////////////////////////////////////////////////////////////////////////
  // head shifts out on pop, new word lands behind the survivors
  always_comb begin
    s_next = s_reg;
    push   = in_valid & s_reg.rdy;
    pop    = s_reg.vld & out_ready;
    pos    = s_reg.cnt - {1'b0, pop};
    if (pop) begin
      s_next.d0 = s_reg.d1;
    end
    if (push) begin
      if (pos == 2'h0) begin
        s_next.d0 = in_data;
      end else begin
        s_next.d1 = in_data;
      end
    end
    s_next.cnt = pos + {1'b0, push};
    s_next.vld = s_next.cnt != 2'h0;
    s_next.rdy = s_next.cnt != 2'h2;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{d0: '0, d1: '0, cnt: 2'h0, vld: 1'b0, rdy: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready  = s_reg.rdy;
  assign out_valid = s_reg.vld;
  assign out_data  = s_reg.d0;

endmodule

// ---- verilog/chf_channel.sv ----
`timescale 1ns/1ps
// How it works
// - command E8h writes, E9h reads contact filter byte; bit 0 selects read
// - low four data bits give filter sampling period in 1 ms steps
// - period zero bypasses this channel's contact filter only
// - host writes zero to reserved bits; reads need not return zero
// - receive fir sums current and delayed samples via shift-and-add; balance fir takes one sample
// - impedance and balance recursive parts: output = input + coeff * last
// - equalizer recursive part: first difference plus scaled feedback
// - coefficients are nested signed shifts, each relative to the previous
// - each term is a nibble: sign bit on top, 3-bit shift below
// - shift code is plain binary, 0 to 7 right shifts
// - term one is most significant; coefficient index picks the tap
// - datapath holds coefficients of magnitude up to term count
// - four terms mostly, three in balance fir, two in post-gain
// - transmit gain applies one plus the decoded coefficient
// - transmit cutoff floats pcm output and strobe, beats loopbacks
// - receive cutoff zeroes receive signal, blocking full loopback, tone, balance; slot loopback still passes
// - highpass disable bypasses transmit highpass stage
// - receive gain reduce halves the receive signal
// - armed interrupt sets on new transmit sample, clears when read
// - command CDh returns transmit upper byte then a reserved byte
// - slot loopback puts receive slot data onto the transmit slot
// - full loopback: analog off, output into transmit input, no impedance
// - tone bit replaces receive slot data with a 1 kHz tone
module chf_channel #(
  parameter int TAPS      = chf_pkg::RX_TAPS,
  parameter int MS_CYCLES = chf_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // host command bytes in
  input  wire logic                      cmd_valid,
  input  wire logic [7:0]                cmd_data,
  output logic                           cmd_ready,
  // host answer bytes out
  output logic                           rsp_valid,
  output logic [7:0]                     rsp_data,
  input  wire logic                      rsp_ready,
  // test states and coefficients
  input  wire chf_pkg::chf_test_t        test,
  input  wire logic [4:0]                analog_impedance_scaling,
  input  wire chf_pkg::chf_coef_t        coef,
  input  wire logic [TAPS-1:0][15:0]     rx_fir_coef,
  // sample stream
  input  wire logic                      sample_tick,
  input  wire logic signed [15:0]        rx_slot_sample,
  input  wire logic signed [15:0]        analog_in,
  output logic signed [15:0]             analog_out,
  output logic                           analog_out_en,
  // transmit slot pins
  input  wire logic                      slot_tick,
  output logic [7:0]                     pcm_transmit_out,
  output logic                           pcm_transmit_out_oe,
  output logic                           transmit_slot_strobe,
  output logic                           transmit_slot_strobe_oe,
  output logic                           transmit_irq,
  // contact detector
  input  wire logic                      line_detect_second_input,
  output logic                           contact_state
);

  localparam int AW = chf_pkg::ACC_W;
  localparam int SW = chf_pkg::SAMPLE_W;
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  typedef enum {ST_CMD, ST_WDATA, ST_RD_CONTACT, ST_RD_TX1, ST_RD_TX2}
    chf_cmd_state_t;

  typedef struct packed {
    chf_cmd_state_t          st;
    logic                    cmd_rdy;
    logic [3:0]              period;
    logic                    sync1;
    logic                    sync2;
    logic [15:0]             ms_cnt;
    logic [3:0]              per_cnt;
    logic                    contact;
    logic [2:0]              tone_idx;
    logic signed [SW-1:0]    eq_x;
    logic signed [SW-1:0]    eq_y;
    logic [TAPS-1:0][SW-1:0] fir_d;
    logic signed [SW-1:0]    ana;
    logic                    ana_en;
    logic signed [SW-1:0]    z_w;
    logic signed [SW-1:0]    b_w;
    logic signed [SW-1:0]    hp_x;
    logic signed [SW-1:0]    hp_y;
    logic signed [SW-1:0]    tx_sample;
    logic                    irq;
    logic [7:0]              pcm;
    logic                    pcm_oe;
    logic                    strobe;
  } chf_state_t;

  chf_state_t s_reg;
  chf_state_t s_next;
  logic       bin_valid;
  logic [7:0] bin_data;
  logic       bin_ready;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers

  // sign extend a sample into the accumulator width
  function automatic logic signed [AW-1:0] ext(input logic signed [SW-1:0] x);
    return {{(AW - SW){x[SW-1]}}, x};
  endfunction

  // clamp an accumulator back to a sample
  function automatic logic signed [SW-1:0] sat(input logic signed [AW-1:0] v);
    logic signed [AW-1:0] hi;
    logic signed [AW-1:0] lo;
    hi = {{(AW - SW + 1){1'b0}}, {(SW - 1){1'b1}}};
    lo = ~hi;
    if (v > hi) begin
      return hi[SW-1:0];
    end else if (v < lo) begin
      return lo[SW-1:0];
    end
    return v[SW-1:0];
  endfunction

  // multiply by a nested signed-digit coefficient, innermost term first
  function automatic logic signed [AW-1:0] sdmul(
    input logic signed [AW-1:0] x,
    input logic [15:0]          c,
    input int                   n
  );
    logic signed [AW-1:0] t;
    logic signed [AW-1:0] s;
    t = x;
    for (int k = 3; k >= 1; k--) begin
      if (k < n) begin
        s = t >>> c[chf_pkg::NIBBLE_W*k +: chf_pkg::SHIFT_W];
        t = c[chf_pkg::NIBBLE_W*k + chf_pkg::SIGN_POS] ? x - s : x + s;
      end
    end
    s = t >>> c[chf_pkg::SHIFT_W-1:0];
    return c[chf_pkg::SIGN_POS] ? -s : s;
  endfunction

  // eight-step 1 kHz tone
  function automatic logic signed [SW-1:0] tone(input logic [2:0] i);
    unique case (i)
      3'h0, 3'h4: return 16'h0000;
      3'h1, 3'h3: return chf_pkg::TONE_MID;
      3'h2:       return chf_pkg::TONE_PEAK;
      3'h5, 3'h7: return -chf_pkg::TONE_MID;
      3'h6:       return -chf_pkg::TONE_PEAK;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole channel
  always_comb begin
    logic                 full_lb;
    logic signed [SW-1:0] rx_src;
    logic signed [SW-1:0] rx_cut;
    logic signed [AW-1:0] acc;
    logic signed [SW-1:0] gs;
    logic signed [SW-1:0] bal_in;
    logic signed [AW-1:0] zfb;
    logic signed [SW-1:0] tx_src;
    logic signed [SW-1:0] tx_a;
    logic signed [SW-1:0] tx_h;
    logic                 irq_set;
    logic                 irq_clr;
    logic                 take;
    full_lb = 1'b0;
    rx_src  = '0;
    rx_cut  = '0;
    acc     = '0;
    gs      = '0;
    bal_in  = '0;
    zfb     = '0;
    tx_src  = '0;
    tx_a    = '0;
    tx_h    = '0;
    irq_set = 1'b0;
    irq_clr = 1'b0;
    take    = cmd_valid & s_reg.cmd_rdy;
    s_next  = s_reg;
    bin_valid = 1'b0;
    bin_data  = 8'h00;

    // command byte sequencing
    unique case (s_reg.st)
      ST_CMD: begin
        if (take) begin
          if (cmd_data == chf_pkg::CMD_CONTACT_WR) begin
            s_next.st = ST_WDATA;
          end else if (cmd_data == chf_pkg::CMD_CONTACT_RD) begin
            s_next.st = ST_RD_CONTACT;
          end else if (cmd_data == chf_pkg::CMD_TX_READ) begin
            s_next.st = ST_RD_TX1;
          end
        end
      end
      ST_WDATA: begin
        if (take) begin
          // reserved upper bits are dropped
          s_next.period = cmd_data[chf_pkg::PERIOD_LSB +: chf_pkg::PERIOD_W];
          s_next.per_cnt = '0;
          s_next.st = ST_CMD;
        end
      end
      ST_RD_CONTACT: begin
        bin_valid = 1'b1;
        bin_data  = {4'h0, s_reg.period};
        if (bin_ready) begin
          s_next.st = ST_CMD;
        end
      end
      ST_RD_TX1: begin
        bin_valid = 1'b1;
        bin_data  = s_reg.tx_sample[SW-1 -: 8];
        if (bin_ready) begin
          irq_clr   = 1'b1;
          s_next.st = ST_RD_TX2;
        end
      end
      ST_RD_TX2: begin
        bin_valid = 1'b1;
        bin_data  = chf_pkg::TX_BYTE2_VALUE;
        if (bin_ready) begin
          s_next.st = ST_CMD;
        end
      end
    endcase
    s_next.cmd_rdy = (s_next.st == ST_CMD) || (s_next.st == ST_WDATA);

    // contact input: synchronise, then sample once per period
    s_next.sync1 = line_detect_second_input;
    s_next.sync2 = s_reg.sync1;
    s_next.ms_cnt = (s_reg.ms_cnt == MS_LAST) ? '0 : s_reg.ms_cnt + 16'h0001;
    if (s_reg.period == 4'h0) begin
      s_next.contact = s_reg.sync2;
    end else if (s_reg.ms_cnt == MS_LAST) begin
      if (s_reg.per_cnt + 4'h1 >= s_reg.period) begin
        s_next.per_cnt = '0;
        s_next.contact = s_reg.sync2;
      end else begin
        s_next.per_cnt = s_reg.per_cnt + 4'h1;
      end
    end

    // loopback from either the control bit or the scaling code
    full_lb = test.full_digital_loopback |
          (analog_impedance_scaling == chf_pkg::AIS_LOOPBACK_CODE);
    s_next.ana_en = ~full_lb;

    // per-sample filter pipeline
    if (sample_tick) begin
      s_next.tone_idx = s_reg.tone_idx + 3'h1;
      rx_src = test.receive_tone_inject ? tone(s_reg.tone_idx)
                                        : rx_slot_sample;
      rx_cut = test.receive_cutoff ? '0 : rx_src;
      acc = sdmul(ext(rx_cut), coef.rx_gain, chf_pkg::TERMS_FULL);
      if (test.receive_gain_reduce) begin
        acc = acc >>> chf_pkg::RX_REDUCE_SHIFT;
      end
      gs = sat(acc);
      // equalizer recursive part
      acc = ext(gs) - ext(s_reg.eq_x) +
            sdmul(ext(s_reg.eq_y), coef.eq_pole, chf_pkg::TERMS_FULL);
      s_next.eq_x = gs;
      s_next.eq_y = sat(acc);
      // receive fir over current and delayed samples
      s_next.fir_d[0] = s_next.eq_y;
      for (int k = 1; k < TAPS; k++) begin
        s_next.fir_d[k] = s_reg.fir_d[k-1];
      end
      acc = '0;
      for (int k = 0; k < TAPS; k++) begin
        acc = acc + sdmul(ext(s_next.fir_d[k]), rx_fir_coef[k],
                          chf_pkg::TERMS_FULL);
      end
      s_next.ana = sat(acc);

      // balance path, blocked by receive cutoff
      bal_in = test.receive_cutoff ? '0 : s_reg.ana;
      acc = sdmul(ext(bal_in), {4'h0, coef.b_fir}, chf_pkg::TERMS_BFIR) +
            sdmul(ext(s_reg.b_w), coef.b_pole, chf_pkg::TERMS_FULL);
      s_next.b_w = sat(acc);
      // impedance path, zeroed in full loopback
      if (full_lb) begin
        s_next.z_w = '0;
      end else begin
        acc = ext(s_reg.ana) +
              sdmul(ext(s_reg.z_w), coef.z_pole, chf_pkg::TERMS_FULL);
        s_next.z_w = sat(acc);
        zfb = sdmul(ext(s_next.z_w), {8'h00, coef.z_post},
                  chf_pkg::TERMS_POST);
      end

      // transmit path
      tx_src = full_lb ? s_reg.ana : analog_in;
      tx_a = sat(ext(tx_src) - ext(s_next.b_w) - zfb);
      acc = ext(tx_a) - ext(s_reg.hp_x) +
            (ext(s_reg.hp_y) - (ext(s_reg.hp_y) >>> chf_pkg::HP_LEAK_SHIFT));
      s_next.hp_x = tx_a;
      s_next.hp_y = sat(acc);
      tx_h = test.transmit_highpass_disable ? tx_a : s_next.hp_y;
      s_next.tx_sample = sat(ext(tx_h) +
                             sdmul(ext(tx_h), coef.tx_gain,
                                 chf_pkg::TERMS_FULL));
      irq_set = test.transmit_data_irq_arm;
    end

    // new sample wins over a read in the same cycle
    s_next.irq = (s_reg.irq & ~irq_clr) | irq_set;

    // transmit slot drive
    s_next.pcm_oe = 1'b0;
    s_next.strobe = 1'b0;
    if (slot_tick && !test.transmit_cutoff) begin
      s_next.pcm_oe = 1'b1;
      s_next.strobe = 1'b1;
      s_next.pcm    = test.slot_loopback ? rx_slot_sample[SW-1 -: 8]
                                         : s_reg.tx_sample[SW-1 -: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, all controls idle after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg         <= '0;
      s_reg.st      <= ST_CMD;
      s_reg.cmd_rdy <= 1'b1;
      s_reg.period  <= chf_pkg::CONTACT_RESET[3:0];
      s_reg.ana_en  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer buffer toward the host
  chf_buf2 #(
    .W (8)
  ) u_rsp_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (bin_valid),
    .in_data   (bin_data),
    .in_ready  (bin_ready),
    .out_valid (rsp_valid),
    .out_data  (rsp_data),
    .out_ready (rsp_ready)
  );

  // outputs straight from state
  assign cmd_ready               = s_reg.cmd_rdy;
  assign analog_out              = s_reg.ana;
  assign analog_out_en           = s_reg.ana_en;
  assign pcm_transmit_out        = s_reg.pcm;
  assign pcm_transmit_out_oe     = s_reg.pcm_oe;
  assign transmit_slot_strobe    = s_reg.strobe;
  assign transmit_slot_strobe_oe = s_reg.pcm_oe;
  assign transmit_irq            = s_reg.irq;
  assign contact_state           = s_reg.contact;

endmodule

// ---- verilog/chf_pkg.sv ----
package chf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // host command codes, bit 0 selects read
  localparam logic [7:0] CMD_CONTACT_WR = 8'hE8;
  localparam logic [7:0] CMD_CONTACT_RD = 8'hE9;
  localparam logic [7:0] CMD_TX_READ    = 8'hCD;
  localparam int         CMD_RW_BIT     = 0;

  // contact-input filter setting byte
  localparam logic [7:0] CONTACT_RESET  = 8'h00;
  localparam int         PERIOD_LSB     = 0;
  localparam int         PERIOD_W       = 4;
  localparam logic [7:0] TX_BYTE2_VALUE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // clock and filter time base
  localparam int CLK_HZ         = 40_000_000;
  localparam int FILTER_UNIT_MS = 1;
  localparam int MS_CYCLES      = CLK_HZ / 1000 * FILTER_UNIT_MS;
  localparam int MS_CNT_W       = 16;

  ////////////////////////////////////////////////////////////////////////////
  // datapath widths and signed-digit layout
  localparam int SAMPLE_W    = 16;
  localparam int ACC_W       = 20;
  localparam int NIBBLE_W    = 4;
  localparam int SHIFT_W     = 3;
  localparam int SIGN_POS    = 3;
  localparam int TERMS_FULL  = 4;
  localparam int TERMS_BFIR  = 3;
  localparam int TERMS_POST  = 2;
  localparam int RX_TAPS     = 4;

  // fixed shifts in the datapath
  localparam int RX_REDUCE_SHIFT = 1;
  localparam int HP_LEAK_SHIFT   = 4;

  // loopback code of the impedance-scaling register
  localparam logic [4:0] AIS_LOOPBACK_CODE = 5'h10;

  // 1 kHz tone at an 8 kHz sample tick, eight steps per cycle
  localparam logic signed [15:0] TONE_PEAK = 16'h2000;
  localparam logic signed [15:0] TONE_MID  = 16'h16A1;

  ////////////////////////////////////////////////////////////////////////////
  // test-state controls
  typedef struct packed {
    logic transmit_cutoff;
    logic receive_cutoff;
    logic transmit_highpass_disable;
    logic receive_gain_reduce;
    logic transmit_data_irq_arm;
    logic slot_loopback;
    logic full_digital_loopback;
    logic receive_tone_inject;
  } chf_test_t;

  // filter coefficients, term x in nibble x-1
  typedef struct packed {
    logic [15:0] tx_gain;
    logic [15:0] rx_gain;
    logic [15:0] eq_pole;
    logic [15:0] z_pole;
    logic [7:0]  z_post;
    logic [11:0] b_fir;
    logic [15:0] b_pole;
  } chf_coef_t;

endpackage
